// *** rtl/uple_endpoint.sv ***
// Device endpoint protocol layer: bursts, acknowledgements, flow control
`timescale 1ns/1ps
module uple_endpoint
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Link receive side
	input wire logic rx_hdr_valid,
	input wire uple_pkg::uple_rxh_s rx_hdr,
	input wire logic rx_pay_valid,
	input wire uple_pkg::uple_pay_s rx_pay,
	// Link transmit side
	output logic tx_hdr_valid,
	input wire logic tx_hdr_ready,
	output uple_pkg::uple_hdr_s tx_hdr,
	output logic tx_pay_valid,
	output logic [uple_pkg::DATA_W-1:0] tx_pay,
	output logic link_retry,
	// Endpoint configuration
	input wire logic [uple_pkg::EP_W-1:0] ep_num,
	input wire uple_pkg::uple_xfer_e xfer_type,
	input wire logic gen2,
	input wire logic [uple_pkg::AW_W-1:0] arb_weight,
	input wire logic [uple_pkg::STRM_W-1:0] strm_sel,
	// Application OUT data
	input wire logic out_ready,
	output logic out_valid,
	output logic [uple_pkg::DATA_W-1:0] out_data,
	output logic [uple_pkg::STRM_W-1:0] out_strm,
	// Application IN data
	input wire logic in_avail,
	output logic in_req,
	output logic [uple_pkg::SEQ_W-1:0] in_seq,
	input wire logic [uple_pkg::DATA_W-1:0] in_data,
	// Host timestamp
	output logic ts_valid,
	output logic [uple_pkg::TS_W-1:0] ts_value
);
	//------------------------------------------------------------------
	// Declarations
	//------------------------------------------------------------------
	uple_pkg::uple_hdr_s h;
	uple_pkg::uple_hdr_s tx_hdr_reg;
	uple_pkg::uple_hdr_s tx_next;
	uple_pkg::uple_txst_e state_reg;
	uple_pkg::uple_txst_e state_next;
	logic [uple_pkg::NUMP_W-1:0] burst_left_reg;
	logic [uple_pkg::NUMP_W-1:0] burst_left_next;
	logic [uple_pkg::SEQ_W-1:0] in_seq_reg;
	logic [uple_pkg::SEQ_W-1:0] in_seq_next;
	logic [uple_pkg::SEQ_W-1:0] exp_seq_reg;
	logic [uple_pkg::SEQ_W-1:0] exp_seq_inc;
	logic [uple_pkg::SEQ_W-1:0] out_seq_reg;
	logic [uple_pkg::SEQ_W-1:0] ack_seq_reg;
	logic [uple_pkg::STRM_W-1:0] strm_reg;
	logic [uple_pkg::STRM_W-1:0] out_strm_hdr_reg;
	logic [uple_pkg::STRM_W-1:0] out_strm_reg;
	logic [uple_pkg::DATA_W-1:0] tx_pay_reg;
	logic [uple_pkg::DATA_W-1:0] out_data_reg;
	logic [uple_pkg::TS_W-1:0] ts_value_reg;
	logic tx_hdr_valid_reg;
	logic tx_pay_valid_reg;
	logic out_valid_reg;
	logic ts_valid_reg;
	logic pay_wait_reg;
	logic ack_pend_reg;
	logic ack_retry_reg;
	logic nrdy_in_pend_reg;
	logic nrdy_out_pend_reg;
	logic req_seen_reg;
	logic hdr_ok;
	logic is_tstamp;
	logic is_in_req;
	logic is_out_data;
	logic start_ok;
	logic pay_take;
	logic pay_good;
	logic pay_stall;
	logic burst_dry;
	logic tx_free;
	logic nrdy_any;
	logic erdy_any;
	logic erdy_in_req;
	logic erdy_out_req;
	logic pick_ack;
	logic pick_nrdy;
	logic pick_erdy;
	logic pick_data;
	logic nrdy_in_sel;
	logic nrdy_out_sel;
	logic erdy_in_sel;
	logic erdy_out_sel;
	logic tx_load;

	//------------------------------------------------------------------
	// Header screen and flow control trackers
	//------------------------------------------------------------------
	uple_hdr_chk u_hdr_chk
	(
		.sys_clk(sys_clk),
		.reset(reset),
		.rx_hdr_valid(rx_hdr_valid),
		.rx_hdr(rx_hdr),
		.hdr_ok(hdr_ok),
		.link_retry(link_retry)
	);

	uple_fc_trk u_fc_in
	(
		.sys_clk(sys_clk),
		.reset(reset),
		.fc_hit(nrdy_in_sel),
		.ready_lvl(in_avail),
		.erdy_taken(erdy_in_sel),
		.erdy_req(erdy_in_req)
	);

	uple_fc_trk u_fc_out
	(
		.sys_clk(sys_clk),
		.reset(reset),
		.fc_hit(nrdy_out_sel),
		.ready_lvl(out_ready),
		.erdy_taken(erdy_out_sel),
		.erdy_req(erdy_out_req)
	);

	//------------------------------------------------------------------
	// Receive decode
	//------------------------------------------------------------------
	// No address compare: whatever arrives is meant for this device
	assign h = rx_hdr.hdr;
	assign is_tstamp = hdr_ok && h.htype == uple_pkg::UPLE_HT_TSTAMP;
	assign is_in_req = hdr_ok && h.htype == uple_pkg::UPLE_HT_ACK && h.dir_in;
	assign is_out_data = hdr_ok && h.htype == uple_pkg::UPLE_HT_DATA && !h.dir_in;
	assign start_ok = is_in_req && in_avail && h.nump != uple_pkg::UPLE_NUMP_ZERO;
	// Payload is only taken after its own header
	assign pay_take = rx_pay_valid && pay_wait_reg;
	assign pay_good = pay_take && out_ready && rx_pay.crc_ok && out_seq_reg == exp_seq_reg;
	assign pay_stall = pay_take && !out_ready;
	assign exp_seq_inc = exp_seq_reg + uple_pkg::UPLE_SEQ_ONE;
	assign burst_dry = state_reg == uple_pkg::UPLE_TX_BURST && !in_avail;

	//------------------------------------------------------------------
	// Transmit arbitration
	//------------------------------------------------------------------
	// Acknowledgements slip between data packets without ending the burst
	assign tx_free = !tx_hdr_valid_reg || tx_hdr_ready;
	assign nrdy_any = nrdy_in_pend_reg || nrdy_out_pend_reg;
	assign erdy_any = erdy_in_req || erdy_out_req;
	assign pick_ack = tx_free && ack_pend_reg;
	assign pick_nrdy = tx_free && !ack_pend_reg && nrdy_any;
	assign pick_erdy = tx_free && !ack_pend_reg && !nrdy_any && erdy_any;
	// Data leaves only inside a burst the host asked for
	assign pick_data = tx_free && !ack_pend_reg && !nrdy_any && !erdy_any &&
		state_reg == uple_pkg::UPLE_TX_BURST && in_avail;
	assign nrdy_in_sel = pick_nrdy && nrdy_in_pend_reg;
	assign nrdy_out_sel = pick_nrdy && !nrdy_in_pend_reg;
	assign erdy_in_sel = pick_erdy && erdy_in_req;
	assign erdy_out_sel = pick_erdy && !erdy_in_req;
	assign tx_load = pick_ack || pick_nrdy || pick_erdy || pick_data;

	// Header builder; no route field, upstream needs none
	function automatic uple_pkg::uple_hdr_s mk_hdr(input uple_pkg::uple_htype_e t,
		input logic d, input logic [uple_pkg::SEQ_W-1:0] s,
		input logic [uple_pkg::NUMP_W-1:0] n, input logic r);
		uple_pkg::uple_hdr_s v;
		v = '0;
		v.htype = t;
		v.subtype = uple_pkg::UPLE_SUB_NONE;
		v.lcw = uple_pkg::UPLE_LCW_NONE;
		v.ep = ep_num;
		v.dir_in = d;
		v.seq = s;
		v.nump = n;
		v.retry = r;
		v.xfer = uple_pkg::UPLE_XT_NONE;
		if (gen2 && (t == uple_pkg::UPLE_HT_ACK || t == uple_pkg::UPLE_HT_DATA))
			v.xfer = xfer_type;
		v.aw = uple_pkg::UPLE_AW_NONE;
		if (gen2 && t == uple_pkg::UPLE_HT_DATA && xfer_type != uple_pkg::UPLE_XT_ISO)
			v.aw = arb_weight;
		v.strm = (t == uple_pkg::UPLE_HT_DATA) ? strm_reg : uple_pkg::UPLE_STRM_NONE;
		return v;
	endfunction

	// Procedural so the builder's hidden reads of configuration stay in the sensitivity
	always_comb
	begin
		if (pick_ack)
			tx_next = mk_hdr(uple_pkg::UPLE_HT_ACK, 1'b0, ack_seq_reg,
				uple_pkg::UPLE_NUMP_ONE, ack_retry_reg);
		else if (pick_nrdy)
			tx_next = mk_hdr(uple_pkg::UPLE_HT_NRDY, nrdy_in_sel, uple_pkg::UPLE_SEQ_RST,
				uple_pkg::UPLE_NUMP_ZERO, 1'b0);
		else if (pick_erdy)
			tx_next = mk_hdr(uple_pkg::UPLE_HT_ERDY, erdy_in_sel, uple_pkg::UPLE_SEQ_RST,
				uple_pkg::UPLE_NUMP_ZERO, 1'b0);
		else
			tx_next = mk_hdr(uple_pkg::UPLE_HT_DATA, 1'b1, in_seq_reg, burst_left_reg,
				1'b0);
	end

	assign tx_hdr_valid = tx_hdr_valid_reg;
	assign tx_hdr = tx_hdr_reg;
	assign tx_pay_valid = tx_pay_valid_reg;
	assign tx_pay = tx_pay_reg;
	assign in_req = pick_data;
	assign in_seq = in_seq_reg;

	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			tx_hdr_valid_reg <= 1'b0;
			tx_pay_valid_reg <= 1'b0;
			tx_hdr_reg <= '0;
			tx_pay_reg <= '0;
		end
		else if (tx_free)
		begin
			tx_hdr_valid_reg <= tx_load;
			tx_pay_valid_reg <= pick_data;
			tx_hdr_reg <= tx_next;
			tx_pay_reg <= in_data;
		end
	end

	//------------------------------------------------------------------
	// IN burst engine
	//------------------------------------------------------------------
	// A new request rewinds the sequence to what the host still expects
	always_comb
	begin
		state_next = state_reg;
		burst_left_next = burst_left_reg;
		in_seq_next = in_seq_reg;
		case (state_reg)
			uple_pkg::UPLE_TX_IDLE:
			begin
				if (start_ok)
					state_next = uple_pkg::UPLE_TX_BURST;
			end
			uple_pkg::UPLE_TX_BURST:
			begin
				if (!in_avail)
					state_next = uple_pkg::UPLE_TX_IDLE;
				else if (pick_data && burst_left_reg == uple_pkg::UPLE_NUMP_ONE && !is_in_req)
					state_next = uple_pkg::UPLE_TX_IDLE;
			end
			default:
				state_next = uple_pkg::UPLE_TX_IDLE;
		endcase
		if (pick_data)
		begin
			burst_left_next = burst_left_reg - uple_pkg::UPLE_NUMP_ONE;
			in_seq_next = in_seq_reg + uple_pkg::UPLE_SEQ_ONE;
		end
		if (is_in_req)
		begin
			burst_left_next = h.nump;
			in_seq_next = h.seq;
			if (h.nump == uple_pkg::UPLE_NUMP_ZERO || !in_avail)
				state_next = uple_pkg::UPLE_TX_IDLE;
			else
				state_next = uple_pkg::UPLE_TX_BURST;
		end
	end

	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			state_reg <= uple_pkg::UPLE_TX_IDLE;
			burst_left_reg <= uple_pkg::UPLE_NUMP_ZERO;
			in_seq_reg <= uple_pkg::UPLE_SEQ_RST;
			strm_reg <= uple_pkg::UPLE_STRM_NONE;
		end
		else
		begin
			state_reg <= state_next;
			burst_left_reg <= burst_left_next;
			in_seq_reg <= in_seq_next;
			if (is_in_req)
				strm_reg <= strm_sel;
		end
	end

	//------------------------------------------------------------------
	// OUT receive, acknowledgement and flow control
	//------------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			pay_wait_reg <= 1'b0;
			out_seq_reg <= uple_pkg::UPLE_SEQ_RST;
			out_strm_hdr_reg <= uple_pkg::UPLE_STRM_NONE;
			exp_seq_reg <= uple_pkg::UPLE_SEQ_RST;
		end
		else
		begin
			pay_wait_reg <= is_out_data || (pay_wait_reg && !pay_take);
			if (is_out_data)
			begin
				out_seq_reg <= h.seq;
				out_strm_hdr_reg <= h.strm;
			end
			if (pay_good)
				exp_seq_reg <= exp_seq_inc;
		end
	end

	// Flags set by events win over the clear of their send
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			ack_pend_reg <= 1'b0;
			ack_retry_reg <= 1'b0;
			ack_seq_reg <= uple_pkg::UPLE_SEQ_RST;
			nrdy_in_pend_reg <= 1'b0;
			nrdy_out_pend_reg <= 1'b0;
		end
		else
		begin
			ack_pend_reg <= (pay_take && out_ready) || (ack_pend_reg && !pick_ack);
			if (pay_take && out_ready)
			begin
				ack_retry_reg <= !pay_good;
				ack_seq_reg <= pay_good ? exp_seq_inc : exp_seq_reg;
			end
			nrdy_in_pend_reg <= (is_in_req && !in_avail && h.nump != uple_pkg::UPLE_NUMP_ZERO)
				|| burst_dry || (nrdy_in_pend_reg && !nrdy_in_sel);
			nrdy_out_pend_reg <= pay_stall || (nrdy_out_pend_reg && !nrdy_out_sel);
		end
	end

	assign out_valid = out_valid_reg;
	assign out_data = out_data_reg;
	assign out_strm = out_strm_reg;
	assign ts_valid = ts_valid_reg;
	assign ts_value = ts_value_reg;

	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			out_valid_reg <= 1'b0;
			out_data_reg <= '0;
			out_strm_reg <= uple_pkg::UPLE_STRM_NONE;
			ts_valid_reg <= 1'b0;
			ts_value_reg <= '0;
			req_seen_reg <= 1'b0;
		end
		else
		begin
			out_valid_reg <= pay_good;
			if (pay_good)
			begin
				out_data_reg <= rx_pay.data;
				out_strm_reg <= out_strm_hdr_reg;
			end
			ts_valid_reg <= is_tstamp;
			if (is_tstamp)
				ts_value_reg <= h.ts;
			req_seen_reg <= req_seen_reg || is_in_req;
		end
	end

	//------------------------------------------------------------------
	// Checks
	//------------------------------------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (reset);

	sequence s_back_to_back;
		pick_data && !is_in_req ##1 pick_data && !is_in_req;
	endsequence

	chk_data_solicited: assert property (
		tx_hdr_valid && tx_hdr.htype == uple_pkg::UPLE_HT_DATA |-> req_seen_reg)
		else $error("data sent before any host request");
	chk_burst_count: assert property (
		start_ok |=> state_reg == uple_pkg::UPLE_TX_BURST &&
			burst_left_reg == $past(rx_hdr.hdr.nump))
		else $error("host request did not open a burst of its size");
	chk_seq_rewind: assert property (
		start_ok |=> in_seq_reg == $past(rx_hdr.hdr.seq))
		else $error("burst did not restart at requested sequence");
	chk_ack_good: assert property (
		pay_good |=> ack_pend_reg && !ack_retry_reg && ack_seq_reg == $past(exp_seq_inc))
		else $error("good payload not acknowledged with next sequence");
	chk_ack_resend: assert property (
		pay_take && out_ready && !rx_pay.crc_ok |=> ack_pend_reg && ack_retry_reg &&
			!out_valid)
		else $error("corrupt payload not answered with resend request");
	chk_nrdy_out: assert property (
		pay_stall |=> nrdy_out_pend_reg && !out_valid)
		else $error("stalled sink gave no not-ready notice");
	chk_seq_step: assert property (
		s_back_to_back |=> tx_hdr.seq == $past(tx_hdr.seq) + uple_pkg::UPLE_SEQ_ONE)
		else $error("back to back data packets out of order");
	chk_ack_midburst: assert property (
		pick_ack && state_reg == uple_pkg::UPLE_TX_BURST && in_avail && !is_in_req
		|=> tx_hdr.htype == uple_pkg::UPLE_HT_ACK && state_reg == uple_pkg::UPLE_TX_BURST
			&& burst_left_reg == $past(burst_left_reg))
		else $error("acknowledgement disturbed the burst");
	chk_one_ep: assert property (
		tx_hdr_valid && tx_hdr.htype == uple_pkg::UPLE_HT_DATA |-> tx_hdr.ep == ep_num &&
			tx_hdr.dir_in && tx_pay_valid)
		else $error("data packet of a foreign flow in burst");
	chk_gen1_plain: assert property (
		tx_hdr_valid && !gen2 |-> tx_hdr.xfer == uple_pkg::UPLE_XT_NONE &&
			tx_hdr.aw == uple_pkg::UPLE_AW_NONE)
		else $error("first generation packet carries annotation");
	chk_ts_capture: assert property (
		is_tstamp |=> ts_valid && ts_value == $past(rx_hdr.hdr.ts))
		else $error("timestamp not captured");
endmodule

// *** rtl/uple_fc_trk.sv ***
// Flow control tracker: stalled after not-ready, asks for ready when able
`timescale 1ns/1ps
module uple_fc_trk
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Events
	input wire logic fc_hit,
	input wire logic ready_lvl,
	input wire logic erdy_taken,
	// Request
	output logic erdy_req
);
	logic stalled_reg;
	logic stalled_next;

	// A new not-ready in the same cycle as the ready send keeps the stall
	assign stalled_next = fc_hit || (stalled_reg && !erdy_taken);
	assign erdy_req = stalled_reg && ready_lvl && !fc_hit;

	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
			stalled_reg <= 1'b0;
		else
			stalled_reg <= stalled_next;
	end

	chk_erdy_when_able: assert property (@(posedge sys_clk) disable iff (reset)
		fc_hit ##1 (ready_lvl && !fc_hit && !erdy_taken) [*2] |-> erdy_req)
		else $error("ready notice not raised once able again");
	chk_erdy_once: assert property (@(posedge sys_clk) disable iff (reset)
		erdy_taken && !fc_hit |=> !erdy_req)
		else $error("ready notice repeated without a new stall");
endmodule

// *** rtl/uple_hdr_chk.sv ***
// Received header CRC screen and link retry request
`timescale 1ns/1ps
module uple_hdr_chk
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Received header
	input wire logic rx_hdr_valid,
	input wire uple_pkg::uple_rxh_s rx_hdr,
	// Result
	output logic hdr_ok,
	output logic link_retry
);
	logic crc_good;
	logic retry_reg;

	assign crc_good = rx_hdr.hdr_crc_ok && rx_hdr.lcw_crc_ok;
	// Bad headers never reach the protocol logic
	assign hdr_ok = rx_hdr_valid && crc_good;
	assign link_retry = retry_reg;

	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
			retry_reg <= 1'b0;
		else
			retry_reg <= rx_hdr_valid && !crc_good;
	end

	chk_retry_on_crc: assert property (@(posedge sys_clk) disable iff (reset)
		rx_hdr_valid && !crc_good |=> link_retry ##1 !link_retry || $past(rx_hdr_valid))
		else $error("header CRC failure gave no link retry");
	chk_bad_hdr_dropped: assert property (@(posedge sys_clk) disable iff (reset)
		rx_hdr_valid && !rx_hdr.lcw_crc_ok |-> !hdr_ok)
		else $error("header with bad link word passed on");
endmodule

// *** rtl/uple_pkg.sv ***
// Protocol layer endpoint constants, packet layouts and state types
//------------------------------------------------------------------
// Behaviour
// - Data moves only when the host asks; device never starts a transfer.
// - Device can ask host for endpoint service without being polled.
// - Device takes every received protocol packet as addressed to itself.
// - Device packets go upstream with no routing decision.
// - Headers are fixed size with type, subtype and a hop-by-hop record.
// - Headers arrive reliably through the link; payloads do not.
// - Receiver acknowledges data explicitly; sender resends lost or corrupt data.
// - Packets arrive in exactly the order the sender sent them.
// - Bursts go back to back while acknowledgements flow without breaking them.
// - Device signals flow control by packet; host drops the pipe.
// - Endpoint sends ready packet when able again; host reschedules pipe.
// - Bulk data carries a stream tag; device picks the active stream.
// - On first generation a burst holds one endpoint flow only.
// - Host sends periodic timestamp headers; hubs forward them to awake paths.
// - Second generation marks transfer type and upstream arbitration weight.
// - Header or link word CRC fail means link retry; payload fail, resend.
//------------------------------------------------------------------
package uple_pkg;

	localparam int EP_W = 4;
	localparam int SEQ_W = 5;
	localparam int NUMP_W = 5;
	localparam int STRM_W = 16;
	localparam int AW_W = 4;
	localparam int TS_W = 27;
	localparam int LCW_W = 11;
	localparam int SUB_W = 4;
	localparam int DATA_W = 32;

	localparam logic [SEQ_W-1:0] UPLE_SEQ_ONE = 5'h01;
	localparam logic [SEQ_W-1:0] UPLE_SEQ_RST = 5'h00;
	localparam logic [NUMP_W-1:0] UPLE_NUMP_ZERO = 5'h00;
	localparam logic [NUMP_W-1:0] UPLE_NUMP_ONE = 5'h01;
	localparam logic [STRM_W-1:0] UPLE_STRM_NONE = 16'h0000;
	localparam logic [AW_W-1:0] UPLE_AW_NONE = 4'h0;
	localparam logic [LCW_W-1:0] UPLE_LCW_NONE = 11'h000;
	localparam logic [SUB_W-1:0] UPLE_SUB_NONE = 4'h0;

	typedef enum logic [2:0] {
		UPLE_HT_DATA, UPLE_HT_ACK, UPLE_HT_NRDY, UPLE_HT_ERDY, UPLE_HT_TSTAMP
	} uple_htype_e;

	typedef enum logic [2:0] {
		UPLE_XT_NONE, UPLE_XT_CTRL, UPLE_XT_ISO, UPLE_XT_BULK, UPLE_XT_INT
	} uple_xfer_e;

	typedef enum logic {UPLE_TX_IDLE, UPLE_TX_BURST} uple_txst_e;

	// Fixed size header; lcw is the hop-by-hop record
	typedef struct packed {
		uple_htype_e htype;
		logic [SUB_W-1:0] subtype;
		logic [LCW_W-1:0] lcw;
		logic [EP_W-1:0] ep;
		logic dir_in;
		logic [SEQ_W-1:0] seq;
		logic [NUMP_W-1:0] nump;
		logic retry;
		uple_xfer_e xfer;
		logic [AW_W-1:0] aw;
		logic [STRM_W-1:0] strm;
		logic [TS_W-1:0] ts;
	} uple_hdr_s;

	typedef struct packed {
		uple_hdr_s hdr;
		logic hdr_crc_ok;
		logic lcw_crc_ok;
	} uple_rxh_s;

	typedef struct packed {
		logic [DATA_W-1:0] data;
		logic crc_ok;
	} uple_pay_s;

endpackage

// *** tb/uple_endpoint_tb.sv ***
// Self-checking bench for the endpoint protocol layer
`timescale 1ns/1ps
module uple_endpoint_tb;
	logic sys_clk, reset, stall, out_ready, in_avail, gen2;
	logic rx_hdr_valid, rx_pay_valid, tx_hdr_valid, tx_hdr_ready, tx_pay_valid;
	logic link_retry, out_valid, in_req, ts_valid;
	uple_pkg::uple_rxh_s rx_hdr;
	uple_pkg::uple_pay_s rx_pay;
	uple_pkg::uple_hdr_s tx_hdr, h;
	logic [31:0] tx_pay, out_data, in_data, out_last;
	logic [15:0] out_strm;
	logic [4:0] in_seq;
	logic [26:0] ts_value, ts_last;
	logic [39:0] p;
	int miscompares, checks_done, cycles, outs, tss, retries, in_reqs;
	assign in_data = {27'h2a5a5a5, in_seq};
	uple_host_model host (.sys_clk(sys_clk), .stall(stall), .rx_hdr_valid(rx_hdr_valid),
		.rx_hdr(rx_hdr), .rx_pay_valid(rx_pay_valid), .rx_pay(rx_pay),
		.tx_hdr_ready(tx_hdr_ready), .tx_hdr_valid(tx_hdr_valid), .tx_hdr(tx_hdr),
		.tx_pay_valid(tx_pay_valid), .tx_pay(tx_pay));
	uple_endpoint dut (.sys_clk(sys_clk), .reset(reset), .rx_hdr_valid(rx_hdr_valid),
		.rx_hdr(rx_hdr), .rx_pay_valid(rx_pay_valid), .rx_pay(rx_pay),
		.tx_hdr_valid(tx_hdr_valid), .tx_hdr_ready(tx_hdr_ready), .tx_hdr(tx_hdr),
		.tx_pay_valid(tx_pay_valid), .tx_pay(tx_pay), .link_retry(link_retry),
		.ep_num(4'h3), .xfer_type(uple_pkg::UPLE_XT_BULK), .gen2(gen2),
		.arb_weight(4'h6), .strm_sel(16'h0c0d), .out_ready(out_ready),
		.out_valid(out_valid), .out_data(out_data), .out_strm(out_strm),
		.in_avail(in_avail), .in_req(in_req), .in_seq(in_seq), .in_data(in_data),
		.ts_valid(ts_valid), .ts_value(ts_value));
	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	//----------------------------------------
	// Monitors, compares and closing
	//----------------------------------------
	always @(posedge sys_clk)
	begin
		cycles++;
		if (out_valid === 1'b1)
		begin
			outs++;
			out_last = out_data;
		end
		if (ts_valid === 1'b1)
		begin
			tss++;
			ts_last = ts_value;
		end
		if (link_retry === 1'b1)
			retries++;
		if (in_req === 1'b1)
			in_reqs++;
		if (cycles == 3000)
		begin
			miscompares++;
			conclude();
		end
	end
	task automatic conclude();
		if (miscompares == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string n, input logic [39:0] e, input logic [39:0] g);
		checks_done++;
		if (g !== e)
		begin
			miscompares++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask
	// Takes the next header the host saw and judges its main fields
	task automatic chk_hdr(input uple_pkg::uple_htype_e t, input logic d, input logic [4:0] s,
		input logic [4:0] np, input logic r);
		repeat (40)
			if (host.got.size() == 0)
				@(posedge sys_clk);
		h = host.got.size() > 0 ? host.got.pop_front() : 'x;
		p = host.pays.size() > 0 ? host.pays.pop_front() : 'x;
		chk("htype", t, h.htype);
		chk("dir_in", d, h.dir_in);
		chk("seq", s, h.seq);
		chk("nump", np, h.nump);
		chk("retry", r, h.retry);
	endtask
	function automatic uple_pkg::uple_rxh_s mk(uple_pkg::uple_htype_e t, logic d,
		logic [4:0] s, logic [4:0] np, logic [1:0] ok);
		mk = '0;
		mk.hdr.htype = t;
		mk.hdr.dir_in = d;
		mk.hdr.seq = s;
		mk.hdr.nump = np;
		mk.hdr.ep = 4'h9;
		{mk.hdr_crc_ok, mk.lcw_crc_ok} = ok;
	endfunction
	task automatic out_pkt(input logic [4:0] s, input logic [31:0] d, input logic ok);
		uple_pkg::uple_rxh_s r;
		r = mk(uple_pkg::UPLE_HT_DATA, 1'b0, s, 5'h01, 2'h3);
		r.hdr.strm = 16'h0b0e;
		host.send_hdr(r);
		host.send_pay(d, ok);
		repeat (3) @(posedge sys_clk);
	endtask
	//----------------------------------------
	// Scenarios
	//----------------------------------------
	task automatic t_out();
		out_pkt(5'h00, 32'h1234abcd, 1'b1);
		chk("outs", 1, outs);
		chk("out_data", 32'h1234abcd, out_last);
		chk("out_strm", 16'h0b0e, out_strm);
		chk_hdr(uple_pkg::UPLE_HT_ACK, 1'b0, 5'h01, 5'h01, 1'b0);
		chk("gen1 xfer", uple_pkg::UPLE_XT_NONE, h.xfer);
	endtask
	task automatic t_err();
		host.send_hdr(mk(uple_pkg::UPLE_HT_DATA, 1'b0, 5'h01, 5'h01, 2'h1));
		host.send_hdr(mk(uple_pkg::UPLE_HT_DATA, 1'b0, 5'h01, 5'h01, 2'h2));
		repeat (2) @(posedge sys_clk);
		chk("retries", 2, retries);
		out_pkt(5'h01, 32'h0bad0bad, 1'b0);
		chk_hdr(uple_pkg::UPLE_HT_ACK, 1'b0, 5'h01, 5'h01, 1'b1);
		out_pkt(5'h00, 32'h0bad0bad, 1'b1);
		chk_hdr(uple_pkg::UPLE_HT_ACK, 1'b0, 5'h01, 5'h01, 1'b1);
		out_pkt(5'h01, 32'h55aa00ff, 1'b1);
		chk_hdr(uple_pkg::UPLE_HT_ACK, 1'b0, 5'h02, 5'h01, 1'b0);
		chk("outs", 2, outs);
	endtask
	task automatic t_flow();
		out_ready <= 1'b0;
		out_pkt(5'h02, 32'h77777777, 1'b1);
		chk_hdr(uple_pkg::UPLE_HT_NRDY, 1'b0, 5'h00, 5'h00, 1'b0);
		chk("outs", 2, outs);
		out_ready <= 1'b1;
		chk_hdr(uple_pkg::UPLE_HT_ERDY, 1'b0, 5'h00, 5'h00, 1'b0);
	endtask
	task automatic t_in();
		uple_pkg::uple_rxh_s r;
		gen2 <= 1'b1;
		stall <= 1'b1;
		in_avail <= 1'b1;
		host.send_hdr(mk(uple_pkg::UPLE_HT_ACK, 1'b1, 5'h03, 5'h02, 2'h3));
		for (int i = 0; i < 2; i++)
		begin
			chk_hdr(uple_pkg::UPLE_HT_DATA, 1'b1, 5'h03 + i, 5'h02 - i, 1'b0);
			chk("xfer", uple_pkg::UPLE_XT_BULK, h.xfer);
			chk("aw", 4'h6, h.aw);
			chk("strm", 16'h0c0d, h.strm);
			chk("pay", {8'h01, 27'h2a5a5a5, 5'h03 + 5'(i)}, p);
		end
		chk("in_reqs", 2, in_reqs);
		r = mk(uple_pkg::UPLE_HT_TSTAMP, 1'b0, 5'h00, 5'h00, 2'h3);
		r.hdr.ts = 27'h1abcdef;
		host.send_hdr(r);
		repeat (2) @(posedge sys_clk);
		chk("ts", 27'h1abcdef, ts_last);
		chk("tss", 1, tss);
	endtask
	task automatic t_in_stall();
		gen2 <= 1'b0;
		stall <= 1'b0;
		in_avail <= 1'b0;
		host.send_hdr(mk(uple_pkg::UPLE_HT_ACK, 1'b1, 5'h00, 5'h01, 2'h3));
		chk_hdr(uple_pkg::UPLE_HT_NRDY, 1'b1, 5'h00, 5'h00, 1'b0);
		in_avail <= 1'b1;
		chk_hdr(uple_pkg::UPLE_HT_ERDY, 1'b1, 5'h00, 5'h00, 1'b0);
		repeat (20) @(posedge sys_clk);
		chk("unasked tx", 0, host.got.size());
		host.send_hdr(mk(uple_pkg::UPLE_HT_ACK, 1'b1, 5'h05, 5'h02, 2'h3));
		for (int i = 0; i < 2; i++)
		begin
			chk_hdr(uple_pkg::UPLE_HT_DATA, 1'b1, 5'h05 + i, 5'h02 - i, 1'b0);
			chk("gen1 aw", uple_pkg::UPLE_AW_NONE, h.aw);
			chk("pay seq", 5'h05 + 5'(i), p[4:0]);
		end
		chk("in_reqs", 4, in_reqs);
	endtask
	initial
	begin
		reset = 1'b1;
		stall = 1'b0;
		out_ready = 1'b1;
		in_avail = 1'b0;
		gen2 = 1'b0;
		repeat (2) @(posedge sys_clk);
		reset <= 1'b0;
		t_out();
		t_err();
		t_flow();
		t_in();
		t_in_stall();
		conclude();
	end
endmodule

// *** tb/uple_host_model.sv ***
// Host side link partner model for the endpoint bench
`timescale 1ns/1ps
module uple_host_model
(
	// Clock and pacing
	input wire logic sys_clk,
	input wire logic stall,
	// Toward the endpoint
	output logic rx_hdr_valid,
	output uple_pkg::uple_rxh_s rx_hdr,
	output logic rx_pay_valid,
	output uple_pkg::uple_pay_s rx_pay,
	output logic tx_hdr_ready,
	// From the endpoint
	input wire logic tx_hdr_valid,
	input wire uple_pkg::uple_hdr_s tx_hdr,
	input wire logic tx_pay_valid,
	input wire logic [uple_pkg::DATA_W-1:0] tx_pay
);
	uple_pkg::uple_hdr_s got[$];
	logic [39:0] pays[$];
	initial
	begin
		rx_hdr_valid = 1'b0;
		rx_hdr = '0;
		rx_pay_valid = 1'b0;
		rx_pay = '0;
		tx_hdr_ready = 1'b0;
	end
	// Slow mode halves acceptance rate to exercise holding
	always @(posedge sys_clk)
	begin
		tx_hdr_ready <= stall ? ~tx_hdr_ready : 1'b1;
		if (tx_hdr_valid && tx_hdr_ready)
		begin
			got.push_back(tx_hdr);
			pays.push_back({7'h00, tx_pay_valid, tx_pay});
		end
	end
	// Released lines show inverted data so stale values never pass
	task automatic send_hdr(input uple_pkg::uple_rxh_s h);
		@(posedge sys_clk);
		rx_hdr_valid <= 1'b1;
		rx_hdr <= h;
		@(posedge sys_clk);
		rx_hdr_valid <= 1'b0;
		rx_hdr <= ~h;
	endtask
	task automatic send_pay(input logic [31:0] d, input logic ok);
		@(posedge sys_clk);
		rx_pay_valid <= 1'b1;
		rx_pay <= {d, ok};
		@(posedge sys_clk);
		rx_pay_valid <= 1'b0;
		rx_pay <= ~{d, ok};
	endtask
endmodule
